/* verilog/timer16_defs.vh */
// Constants for the 16-bit timer with capture: addresses, bit positions, codes
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
`define ADDR_CTRL_A 8'h00
`define ADDR_CTRL_B 8'h04
`define ADDR_CNT_L 8'h08
`define ADDR_CNT_H 8'h0C
`define ADDR_CMPA_L 8'h10
`define ADDR_CMPA_H 8'h14
`define ADDR_CMPB_L 8'h18
`define ADDR_CMPB_H 8'h1C
`define ADDR_CAP_L 8'h20
`define ADDR_CAP_H 8'h24
`define ADDR_MASK 8'h28
`define ADDR_FLAGS 8'h2C
`define CTRLB_FILTER 7
`define CTRLB_EDGE 6
`define CTRLB_RSVD 5
`define CTRLB_WGM_MSB 4
`define CTRLB_WGM_LSB 3
`define CTRLB_CS_MSB 2
`define CTRLA_FORCE_A 3
`define CTRLA_FORCE_B 2
`define IRQ_CAP 5
`define IRQ_CMPA 4
`define IRQ_CMPB 3
`define IRQ_OVF 2
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define PRE_MASK_8 10'h007
`define PRE_MASK_64 10'h03F
`define PRE_MASK_256 10'h0FF
`define PRE_MASK_1024 10'h3FF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define TOP_MAX 16'hFFFF
`define BOTTOM 16'h0000
`define FILTER_SAMPLES 4
`define RST_BYTE 8'h00
`endif

/* verilog/pin_sync_filter.v */
// Two-flop pin synchroniser with an optional equal-sample noise filter
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module pin_sync_filter #(
  parameter FILTER_LEN = `FILTER_SAMPLES
) (
  // Clock, reset, enable
  input wire mclk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Pin and control
  input wire pin_in,
  input wire filter_en_in,
  // Clean level
  output reg level_out
);
  reg meta_r;
  reg sync_r;
  reg [FILTER_LEN-1:0] hist_r;

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      hist_r <= {FILTER_LEN{1'b0}};
      level_out <= 1'b0;
    end else if (ce_in) begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      hist_r <= {hist_r[FILTER_LEN-2:0], sync_r};
      if (!filter_en_in)
        level_out <= sync_r;
      // Output moves only after a full run of equal samples
      else if (&hist_r)
        level_out <= 1'b1;
      else if (~|hist_r)
        level_out <= 1'b0;
    end
  end
endmodule // pin_sync_filter
`default_nettype wire

/* verilog/prescale_tick.v */
// Timer clock selection: prescaled io clock or edges of the count pin
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module prescale_tick (
  // Clock, reset, enable
  input wire mclk_in,
  input wire rst_n_in,
  input wire ce_in,
  // Selection and synchronised count pin level
  input wire [2:0] clock_select_in,
  input wire ext_level_in,
  // One-cycle timer clock enable
  output reg tick_out
);
  reg [9:0] pre_r;
  reg ext_prev_r;
  reg tick_nxt;

  function tap;
    input [9:0] cnt;
    input [9:0] mask;
    begin
      tap = ((cnt & mask) == mask);
    end
  endfunction

  always @* begin
    case (clock_select_in)
      `CS_DIV1: tick_nxt = 1'b1;
      `CS_DIV8: tick_nxt = tap(pre_r, `PRE_MASK_8);
      `CS_DIV64: tick_nxt = tap(pre_r, `PRE_MASK_64);
      `CS_DIV256: tick_nxt = tap(pre_r, `PRE_MASK_256);
      `CS_DIV1024: tick_nxt = tap(pre_r, `PRE_MASK_1024);
      // Pin edges count even while the pin is driven as an output
      `CS_EXT_FALL: tick_nxt = ext_prev_r & ~ext_level_in;
      `CS_EXT_RISE: tick_nxt = ~ext_prev_r & ext_level_in;
      default: tick_nxt = 1'b0;
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_r <= 10'h000;
      ext_prev_r <= 1'b0;
      tick_out <= 1'b0;
    end else if (ce_in) begin
      pre_r <= pre_r + 10'h001;
      ext_prev_r <= ext_level_in;
      tick_out <= tick_nxt;
    end
  end
endmodule // prescale_tick
`default_nettype wire

/* verilog/timer16_capture_control_regs.v */
// 16-bit timer with capture and two compare channels behind an APB slave
//
// What this block does
// - Filter needs four equal capture samples
// - Edge select: zero falling, one rising
// - Capture copies counter, sets capture flag
// - Capture disabled while capture is TOP
// - Clock select stops or divides io clock
// - Codes 110/111 count count-pin falling/rising
// - Count pin counts even when driven
// - Counter bytes share one high-byte latch
// - Counter write blocks next compare match
// - Compare registers compared with counter continuously
// - Compare writes go through high-byte latch
// - Capture source pin or comparator output
// - Capture usable as TOP, latched reads
// - Capture irq enable at mask bit 5
// - Compare A irq enable at bit 4
// - Compare B irq enable at bit 3
// - Overflow irq enable at bit 2
// - Capture flag on capture or TOP
// - Capture flag clears on vector or one
// - Compare flag set after match, cleared likewise
// - Overflow flag timing depends on mode
// - Forced compare sets no flag, no clear
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module timer16_capture_control_regs (
  // Clock, reset, enable
  input wire mclk_in,
  input wire nrst_in,
  input wire ce_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Pins and capture source
  input wire capture_pin_in,
  input wire comparator_out_in,
  input wire capture_from_comparator_in,
  input wire external_count_pin_in,
  // Interrupt side
  input wire global_irq_enable_in,
  input wire capture_ack_in,
  input wire compare_a_ack_in,
  input wire compare_b_ack_in,
  input wire overflow_ack_in,
  output reg capture_irq_out,
  output reg compare_a_irq_out,
  output reg compare_b_irq_out,
  output reg overflow_irq_out,
  // Hooks toward the waveform unit
  output reg compare_match_a_out,
  output reg compare_match_b_out,
  output reg forced_compare_a_out,
  output reg forced_compare_b_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_meta_r;
  reg rst_n;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [1:0] wgm_lo_r;
  reg [7:0] timer_ctrl_b_r;
  reg [15:0] counter_value_r;
  reg [15:0] compare_value_a_r;
  reg [15:0] compare_value_b_r;
  reg [15:0] capture_value_r;
  reg [7:0] temp_r;
  reg [3:0] irq_en_r;
  reg [3:0] irq_flag_r;
  reg count_up_r;
  reg block_match_r;
  reg capture_prev_r;
  reg [7:0] rd_hi_r;
  reg rd_latch_r;

  wire [3:0] waveform_mode = {timer_ctrl_b_r[`CTRLB_WGM_MSB:`CTRLB_WGM_LSB], wgm_lo_r};
  wire [2:0] clock_select = timer_ctrl_b_r[`CTRLB_CS_MSB:0];
  wire capture_filter_enable = timer_ctrl_b_r[`CTRLB_FILTER];
  wire capture_edge_select = timer_ctrl_b_r[`CTRLB_EDGE];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  function [15:0] top_of;
    input [3:0] m;
    input [15:0] cmpa;
    input [15:0] cap;
    begin
      case (m)
        4'h1, 4'h5: top_of = `TOP_8BIT;
        4'h2, 4'h6: top_of = `TOP_9BIT;
        4'h3, 4'h7: top_of = `TOP_10BIT;
        4'h4, 4'h9, 4'hB, 4'hF: top_of = cmpa;
        4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
        default: top_of = `TOP_MAX;
      endcase
    end
  endfunction

  function is_dual_slope;
    input [3:0] m;
    begin
      is_dual_slope = (m == 4'h1) || (m == 4'h2) || (m == 4'h3) || (m[3:2] == 2'h2);
    end
  endfunction

  function is_cap_top;
    input [3:0] m;
    begin
      is_cap_top = m[3] && !m[0];
    end
  endfunction

  function is_fast_pwm;
    input [3:0] m;
    begin
      is_fast_pwm = (m == 4'h5) || (m == 4'h6) || (m == 4'h7) || (m == 4'hE) || (m == 4'hF);
    end
  endfunction

  function is_non_pwm;
    input [3:0] m;
    begin
      is_non_pwm = (m == 4'h0) || (m == 4'h4) || (m == 4'hC);
    end
  endfunction

  wire [15:0] top_value = top_of(waveform_mode, compare_value_a_r, capture_value_r);
  wire dual = is_dual_slope(waveform_mode);
  wire cap_top = is_cap_top(waveform_mode);
  wire at_top = (counter_value_r == top_value);
  wire at_bottom = (counter_value_r == `BOTTOM);

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning and timer clock
  wire capture_level;
  wire count_level;
  wire timer_tick;
  // Mux ahead of the synchroniser so both sources get the same filter
  wire capture_raw = capture_from_comparator_in ? comparator_out_in : capture_pin_in;

  pin_sync_filter #(.FILTER_LEN(`FILTER_SAMPLES)) u_capture_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .pin_in(capture_raw),
    .filter_en_in(capture_filter_enable),
    .level_out(capture_level)
  );

  pin_sync_filter #(.FILTER_LEN(`FILTER_SAMPLES)) u_count_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .pin_in(external_count_pin_in),
    .filter_en_in(1'b0),
    .level_out(count_level)
  );

  prescale_tick u_prescale (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .clock_select_in(clock_select),
    .ext_level_in(count_level),
    .tick_out(timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Events
  wire cap_edge = capture_edge_select ? (capture_level & ~capture_prev_r)
                                      : (~capture_level & capture_prev_r);
  wire capture_event = cap_edge & ~cap_top;
  wire match_a = timer_tick & ~block_match_r & (counter_value_r == compare_value_a_r);
  wire match_b = timer_tick & ~block_match_r & (counter_value_r == compare_value_b_r);
  reg ovf_event;
  always @* begin
    if (dual)
      ovf_event = timer_tick & at_bottom & ~count_up_r;
    else if (is_fast_pwm(waveform_mode))
      ovf_event = timer_tick & at_top;
    else
      ovf_event = timer_tick & (counter_value_r == `TOP_MAX);
  end
  wire cap_flag_set = capture_event | (cap_top & timer_tick & at_top);

  ////////////////////////////////////////////////////////////////////////////
  // APB access
  wire setup = psel_in & ~penable_in & ~pready_out;
  wire access = psel_in & penable_in & pready_out;
  wire wr = access & pwrite_in;
  wire [7:0] wbyte = pwdata_in[7:0];
  reg [7:0] rd_nxt;
  reg [7:0] rd_hi_nxt;
  reg rd_latch_nxt;
  reg err_nxt;

  always @* begin
    rd_nxt = `RST_BYTE;
    rd_hi_nxt = `RST_BYTE;
    rd_latch_nxt = 1'b0;
    err_nxt = 1'b0;
    case (paddr_in)
      `ADDR_CTRL_A: rd_nxt = {6'h00, wgm_lo_r};
      `ADDR_CTRL_B: rd_nxt = timer_ctrl_b_r;
      `ADDR_CNT_L: begin
        rd_nxt = counter_value_r[7:0];
        rd_hi_nxt = counter_value_r[15:8];
        rd_latch_nxt = 1'b1;
      end
      `ADDR_CNT_H: rd_nxt = temp_r;
      `ADDR_CMPA_L: rd_nxt = compare_value_a_r[7:0];
      `ADDR_CMPA_H: rd_nxt = compare_value_a_r[15:8];
      `ADDR_CMPB_L: rd_nxt = compare_value_b_r[7:0];
      `ADDR_CMPB_H: rd_nxt = compare_value_b_r[15:8];
      `ADDR_CAP_L: begin
        rd_nxt = capture_value_r[7:0];
        rd_hi_nxt = capture_value_r[15:8];
        rd_latch_nxt = 1'b1;
      end
      `ADDR_CAP_H: rd_nxt = temp_r;
      `ADDR_MASK: rd_nxt = {2'h0, irq_en_r, 2'h0};
      `ADDR_FLAGS: rd_nxt = {2'h0, irq_flag_r, 2'h0};
      default: err_nxt = 1'b1;
    endcase
  end

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      rd_hi_r <= `RST_BYTE;
      rd_latch_r <= 1'b0;
    end else if (ce_in) begin
      pready_out <= setup;
      if (setup) begin
        // Sample in setup; the access edge then commits the same snapshot
        prdata_out <= pwrite_in ? 32'h00000000 : {24'h000000, rd_nxt};
        pslverr_out <= err_nxt;
        rd_hi_r <= rd_hi_nxt;
        rd_latch_r <= rd_latch_nxt & ~pwrite_in;
      end else if (access) begin
        pslverr_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and shared high-byte latch
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      wgm_lo_r <= 2'h0;
      timer_ctrl_b_r <= `RST_BYTE;
      irq_en_r <= 4'h0;
      temp_r <= `RST_BYTE;
      forced_compare_a_out <= 1'b0;
      forced_compare_b_out <= 1'b0;
    end else if (ce_in) begin
      forced_compare_a_out <= 1'b0;
      forced_compare_b_out <= 1'b0;
      if (access & ~pwrite_in & rd_latch_r)
        temp_r <= rd_hi_r;
      if (wr) begin
        case (paddr_in)
          `ADDR_CTRL_A: begin
            wgm_lo_r <= wbyte[1:0];
            // Strobes only reach the waveform unit: no flag, no counter clear
            forced_compare_a_out <= wbyte[`CTRLA_FORCE_A] & is_non_pwm(waveform_mode);
            forced_compare_b_out <= wbyte[`CTRLA_FORCE_B] & is_non_pwm(waveform_mode);
          end
          `ADDR_CTRL_B: timer_ctrl_b_r <= wbyte & ~(8'h01 << `CTRLB_RSVD);
          `ADDR_CNT_H, `ADDR_CMPA_H, `ADDR_CMPB_H, `ADDR_CAP_H: temp_r <= wbyte;
          `ADDR_MASK: irq_en_r <= wbyte[`IRQ_CAP:`IRQ_OVF];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, compare and capture registers
  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      counter_value_r <= 16'h0000;
      compare_value_a_r <= 16'h0000;
      compare_value_b_r <= 16'h0000;
      capture_value_r <= 16'h0000;
      count_up_r <= 1'b1;
      block_match_r <= 1'b0;
      capture_prev_r <= 1'b0;
    end else if (ce_in) begin
      capture_prev_r <= capture_level;
      if (timer_tick) begin
        block_match_r <= 1'b0;
        if (dual) begin
          if (count_up_r && at_top) begin
            count_up_r <= 1'b0;
            counter_value_r <= counter_value_r - 16'h0001;
          end else if (!count_up_r && at_bottom) begin
            count_up_r <= 1'b1;
            counter_value_r <= counter_value_r + 16'h0001;
          end else if (count_up_r) begin
            counter_value_r <= counter_value_r + 16'h0001;
          end else begin
            counter_value_r <= counter_value_r - 16'h0001;
          end
        end else begin
          count_up_r <= 1'b1;
          counter_value_r <= at_top ? `BOTTOM : counter_value_r + 16'h0001;
        end
      end
      if (capture_event)
        capture_value_r <= counter_value_r;
      // Bus write has priority over count and capture
      if (wr) begin
        case (paddr_in)
          `ADDR_CNT_L: begin
            counter_value_r <= {temp_r, wbyte};
            block_match_r <= 1'b1;
          end
          `ADDR_CMPA_L: compare_value_a_r <= {temp_r, wbyte};
          `ADDR_CMPB_L: compare_value_b_r <= {temp_r, wbyte};
          `ADDR_CAP_L: capture_value_r <= {temp_r, wbyte};
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt lines
  wire wr_flags = wr & (paddr_in == `ADDR_FLAGS);
  wire [3:0] flag_clr = ({4{wr_flags}} & wbyte[`IRQ_CAP:`IRQ_OVF]) |
                        {capture_ack_in, compare_a_ack_in, compare_b_ack_in, overflow_ack_in};
  wire [3:0] flag_set = {cap_flag_set, match_a, match_b, ovf_event};
  wire [3:0] flag_nxt = flag_set | (irq_flag_r & ~flag_clr);
  wire [3:0] irq_nxt = irq_flag_r & irq_en_r & {4{global_irq_enable_in}};

  always @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_r <= 4'h0;
      capture_irq_out <= 1'b0;
      compare_a_irq_out <= 1'b0;
      compare_b_irq_out <= 1'b0;
      overflow_irq_out <= 1'b0;
      compare_match_a_out <= 1'b0;
      compare_match_b_out <= 1'b0;
    end else if (ce_in) begin
      irq_flag_r <= flag_nxt;
      capture_irq_out <= irq_nxt[3];
      compare_a_irq_out <= irq_nxt[2];
      compare_b_irq_out <= irq_nxt[1];
      overflow_irq_out <= irq_nxt[0];
      compare_match_a_out <= match_a;
      compare_match_b_out <= match_b;
    end
  end
endmodule // timer16_capture_control_regs
`default_nettype wire

/* bench/timer16_assertions.sv */
// Checker for the timer block bus and interrupt ports
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module timer16_checker (
  // Clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // Bus
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  // Interrupt side
  input wire global_irq_enable_in,
  input wire capture_irq_out,
  input wire compare_a_irq_out,
  input wire overflow_irq_out,
  input wire forced_compare_a_out,
  input wire forced_compare_b_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////////
  wire acc = psel_in && penable_in;
  wire wr_a = acc && pwrite_in && (paddr_in == `ADDR_CTRL_A);
  wire req_a = wr_a && pwdata_in[`CTRLA_FORCE_A];
  wire req_b = wr_a && pwdata_in[`CTRLA_FORCE_B];
  property p_rdy; psel_in && !penable_in |=> pready_out && acc; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_only; pready_out |-> acc; endproperty
  a_only: assert property (p_only) else $error("ready outside access");
  property p_err; pready_out && (paddr_in > `ADDR_FLAGS) |-> pslverr_out; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_hi; pready_out |-> prdata_out[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_gc; capture_irq_out |-> $past(global_irq_enable_in); endproperty
  a_gc: assert property (p_gc) else $error("capture irq without global");
  property p_ga; compare_a_irq_out |-> $past(global_irq_enable_in); endproperty
  a_ga: assert property (p_ga) else $error("compare irq without global");
  property p_go; overflow_irq_out |-> $past(global_irq_enable_in); endproperty
  a_go: assert property (p_go) else $error("overflow irq without global");
  property p_fa; forced_compare_a_out |-> $past(req_a); endproperty
  a_fa: assert property (p_fa) else $error("stray forced compare a");
  property p_fb; forced_compare_b_out |-> $past(req_b); endproperty
  a_fb: assert property (p_fb) else $error("stray forced compare b");
  c_frc: cover property (forced_compare_a_out);
  c_cap: cover property (capture_irq_out);
  c_err: cover property (pslverr_out);
endmodule // timer16_checker
bind timer16_capture_control_regs timer16_checker chk (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .global_irq_enable_in(global_irq_enable_in), .capture_irq_out(capture_irq_out),
  .compare_a_irq_out(compare_a_irq_out), .overflow_irq_out(overflow_irq_out),
  .forced_compare_a_out(forced_compare_a_out), .forced_compare_b_out(forced_compare_b_out)
);
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the 16-bit timer block over APB
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
module testbench;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, cap = 1'b0, cmp = 1'b0, sel = 1'b0;
  logic tpin = 1'b0, gie = 1'b0, rerr;
  logic [3:0] ack = 4'h0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, rdata;
  logic [15:0] v;
  wire [31:0] prd;
  wire rdy, serr, i_cap, i_a, i_b, i_ovf, f_a, f_b, m_a, m_b;
  integer err_count = 0, n_checks = 0, c, d, n_ma = 0, n_mb = 0;
  always #10 mclk_in = ~mclk_in;
  // Match pulses last one cycle, so they are counted rather than sampled
  always @(posedge mclk_in) begin
    if (m_a === 1'b1) n_ma <= n_ma + 1;
    if (m_b === 1'b1) n_mb <= n_mb + 1;
  end
  timer16_capture_control_regs uut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
    .prdata_out(prd), .pready_out(rdy), .pslverr_out(serr),
    .capture_pin_in(cap), .comparator_out_in(cmp), .capture_from_comparator_in(sel),
    .external_count_pin_in(tpin), .global_irq_enable_in(gie),
    .capture_ack_in(ack[3]), .compare_a_ack_in(ack[2]), .compare_b_ack_in(ack[1]),
    .overflow_ack_in(ack[0]), .capture_irq_out(i_cap), .compare_a_irq_out(i_a),
    .compare_b_irq_out(i_b), .overflow_irq_out(i_ovf), .compare_match_a_out(m_a),
    .compare_match_b_out(m_b), .forced_compare_a_out(f_a), .forced_compare_b_out(f_b)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    begin
      if (err_count == 0 && n_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task check(input logic [31:0] g, input logic [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge mclk_in);
    end
  endtask
  // Request held until ready is sampled; a stuck slave ends the run
  task bus(input logic w, input logic [7:0] a, input logic [7:0] dt);
    integer i;
    begin
      @(posedge mclk_in);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= {24'h0, dt};
      @(posedge mclk_in);
      pen <= 1'b1;
      for (i = 0; i < 20; i = i + 1) begin
        @(posedge mclk_in);
        if (rdy === 1'b1) begin
          rdata = prd;
          rerr = serr;
          i = 30;
        end
      end
      psel <= 1'b0;
      pen <= 1'b0;
      if (i == 20) begin
        check(32'h0, 32'h1);
        tally_and_finish;
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] dt);
    begin
      bus(1'b1, a, dt);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      check({23'h0, rerr, rdata[7:0] & m}, {24'h0, e});
    end
  endtask
  // Low byte first so the high byte comes from the shared latch
  task r16(input logic [7:0] a);
    begin
      bus(1'b0, a, 8'h00);
      v[7:0] = rdata[7:0];
      bus(1'b0, a + 8'h04, 8'h00);
      v[15:8] = rdata[7:0];
    end
  endtask
  task setc(input logic [15:0] x);
    begin
      wr(`ADDR_CNT_H, x[15:8]);
      wr(`ADDR_CNT_L, x[7:0]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    nrst_in <= 1'b1;
    cyc(3);
    rd(`ADDR_CTRL_B, 8'hFF, 8'h00);
    rd(`ADDR_MASK, 8'hFF, 8'h00);
    rd(`ADDR_FLAGS, 8'hFF, 8'h00);
    wr(`ADDR_CTRL_B, 8'hC0);
    rd(`ADDR_CTRL_B, 8'hFF, 8'hC0);
    wr(`ADDR_CTRL_B, 8'h00);
    bus(1'b1, 8'h30, 8'hFF);
    bus(1'b0, 8'h30, 8'h00);
    check({rerr, rdata[30:0]}, 32'h80000000);
    setc(16'h1234);
    r16(`ADDR_CNT_L);
    check({16'h0, v}, 32'h1234);
    // Latch is shared: the last high byte written wins
    wr(`ADDR_CMPA_H, 8'hAB);
    wr(`ADDR_CMPB_H, 8'h56);
    wr(`ADDR_CMPA_L, 8'hCD);
    rd(`ADDR_CMPA_L, 8'hFF, 8'hCD);
    rd(`ADDR_CMPA_H, 8'hFF, 8'h56);
    for (c = 1; c <= 5; c = c + 1) begin
      d = (c == 1) ? 1 : (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024;
      setc(16'h0000);
      wr(`ADDR_CTRL_B, c[7:0]);
      cyc(8 * d);
      wr(`ADDR_CTRL_B, 8'h00);
      r16(`ADDR_CNT_L);
      check({31'h0, (v >= 16'd7) && (v <= (8 * d + 6) / d + 1)}, 32'h1);
    end
    setc(16'h0055);
    cyc(100);
    r16(`ADDR_CNT_L);
    check({16'h0, v}, 32'h0055);
    for (c = 6; c <= 7; c = c + 1) begin
      setc(16'h0000);
      wr(`ADDR_CTRL_B, c[7:0]);
      repeat (5) begin
        @(posedge mclk_in) tpin <= 1'b1;
        cyc(4);
        @(posedge mclk_in) tpin <= 1'b0;
        cyc(4);
      end
      cyc(8);
      wr(`ADDR_CTRL_B, 8'h00);
      r16(`ADDR_CNT_L);
      check({16'h0, v}, 32'h5);
    end
    wr(`ADDR_CMPA_H, 8'h01);
    wr(`ADDR_CMPA_L, 8'h00);
    wr(`ADDR_CMPB_H, 8'h01);
    wr(`ADDR_CMPB_L, 8'h10);
    setc(16'h00F0);
    wr(`ADDR_FLAGS, 8'hFF);
    wr(`ADDR_MASK, 8'h18);
    @(posedge mclk_in) gie <= 1'b1;
    wr(`ADDR_CTRL_B, 8'h01);
    cyc(40);
    wr(`ADDR_CTRL_B, 8'h00);
    rd(`ADDR_FLAGS, 8'h3C, 8'h18);
    check({30'h0, i_a, i_b}, 32'h3);
    check({n_ma[15:0], n_mb[15:0]}, 32'h00010001);
    wr(`ADDR_MASK, 8'h10);
    cyc(2);
    check({30'h0, i_a, i_b}, 32'h2);
    @(posedge mclk_in) ack <= 4'h6;
    @(posedge mclk_in) ack <= 4'h0;
    cyc(2);
    rd(`ADDR_FLAGS, 8'h18, 8'h00);
    check({31'h0, i_a}, 32'h0);
    // A count reload equal to the compare value must not match on the next tick
    setc(16'h0100);
    wr(`ADDR_CTRL_B, 8'h01);
    wr(`ADDR_CTRL_B, 8'h00);
    rd(`ADDR_FLAGS, 8'h10, 8'h00);
    check({n_ma[15:0], n_mb[15:0]}, 32'h00010001);
    wr(`ADDR_CTRL_A, 8'h0C);
    @(posedge mclk_in);
    check({30'h0, f_a, f_b}, 32'h3);
    rd(`ADDR_FLAGS, 8'h18, 8'h00);
    rd(`ADDR_CTRL_A, 8'h0C, 8'h00);
    check({n_ma[15:0], n_mb[15:0]}, 32'h00010001);
    setc(16'hFFFC);
    wr(`ADDR_MASK, 8'h04);
    wr(`ADDR_CTRL_B, 8'h01);
    cyc(20);
    wr(`ADDR_CTRL_B, 8'h00);
    rd(`ADDR_FLAGS, 8'h04, 8'h04);
    check({31'h0, i_ovf}, 32'h1);
    @(posedge mclk_in) gie <= 1'b0;
    cyc(2);
    check({31'h0, i_ovf}, 32'h0);
    @(posedge mclk_in) ack <= 4'h1;
    @(posedge mclk_in) ack <= 4'h0;
    rd(`ADDR_FLAGS, 8'h04, 8'h00);
    setc(16'h0777);
    wr(`ADDR_MASK, 8'h20);
    @(posedge mclk_in) gie <= 1'b1;
    wr(`ADDR_CTRL_B, 8'h40);
    @(posedge mclk_in) cap <= 1'b1;
    cyc(12);
    rd(`ADDR_FLAGS, 8'h20, 8'h20);
    check({31'h0, i_cap}, 32'h1);
    r16(`ADDR_CAP_L);
    check({16'h0, v}, 32'h0777);
    wr(`ADDR_FLAGS, 8'h20);
    cyc(2);
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    check({31'h0, i_cap}, 32'h0);
    @(posedge mclk_in) cap <= 1'b0;
    cyc(12);
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    wr(`ADDR_CTRL_B, 8'h00);
    setc(16'h0123);
    @(posedge mclk_in) cap <= 1'b1;
    cyc(12);
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    @(posedge mclk_in) cap <= 1'b0;
    cyc(12);
    rd(`ADDR_FLAGS, 8'h20, 8'h20);
    r16(`ADDR_CAP_L);
    check({16'h0, v}, 32'h0123);
    @(posedge mclk_in) ack <= 4'h8;
    @(posedge mclk_in) ack <= 4'h0;
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    // Three-cycle glitch, then a real edge seen only after the filter delay
    wr(`ADDR_CTRL_B, 8'hC0);
    @(posedge mclk_in) cap <= 1'b1;
    cyc(2);
    @(posedge mclk_in) cap <= 1'b0;
    cyc(16);
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    @(posedge mclk_in) cap <= 1'b1;
    cyc(3);
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    cyc(12);
    rd(`ADDR_FLAGS, 8'h20, 8'h20);
    wr(`ADDR_FLAGS, 8'h20);
    setc(16'h0BEE);
    wr(`ADDR_CTRL_B, 8'h40);
    @(posedge mclk_in) sel <= 1'b1;
    cyc(12);
    @(posedge mclk_in) cmp <= 1'b1;
    cyc(12);
    r16(`ADDR_CAP_L);
    check({16'h0, v}, 32'h0BEE);
    wr(`ADDR_FLAGS, 8'h20);
    @(posedge mclk_in) sel <= 1'b0;
    wr(`ADDR_CTRL_B, 8'h58);
    setc(16'h0444);
    @(posedge mclk_in) cap <= 1'b0;
    cyc(12);
    @(posedge mclk_in) cap <= 1'b1;
    cyc(12);
    rd(`ADDR_FLAGS, 8'h20, 8'h00);
    r16(`ADDR_CAP_L);
    check({16'h0, v}, 32'h0BEE);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
